// file: hdl/three_port_gpio_block.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"
module three_port_gpio_block (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_a_pin_oe_out,
    output logic [7:0] port_a_pullup_out,
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe_out,
    output logic [7:0] analog_channel_pins_out,
    input wire logic [6:0] port_c_pin_in,
    output logic [6:0] port_c_pin_out,
    output logic [6:0] port_c_pin_oe_out,
    output logic [6:0] port_c_pullup_out,
    output logic [7:0] keypad_inputs_out
);
    gpio_pkg::byte_t lat_a_reg, lat_b_reg, lat_c_reg;
    gpio_pkg::byte_t lat_a_next, lat_b_next, lat_c_next;
    gpio_pkg::byte_t dir_a_reg, dir_b_reg, dir_c_reg;
    gpio_pkg::byte_t dir_a_next, dir_b_next, dir_c_next;
    gpio_pkg::byte_t pull_a_reg, pull_c_reg, pull_a_next, pull_c_next;
    gpio_pkg::byte_t keypad_irq_control_reg, keypad_irq_control_next;
    logic [4:0] analog_sel_reg, analog_sel_next;
    gpio_pkg::byte_t rdata_reg, rdata_next;
    logic [7:0] sync_a, sync_b, sync_c;
    logic [7:0] analog_onehot;

    gpio_pin_if pa();
    gpio_pin_if pb();
    gpio_pin_if pc();

    // first two-flop stage feeds only the second
    gpio_sync u_sync_a (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .async_in(port_a_pin_in), .sync_out(sync_a));
    gpio_sync u_sync_b (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .async_in(port_b_pin_in), .sync_out(sync_b));
    gpio_sync u_sync_c (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .async_in({1'b0, port_c_pin_in}), .sync_out(sync_c));

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // channel codes 0..7 pick a second-port pin; others select none
    always_comb begin
        analog_onehot = 8'h00;
        if (analog_sel_reg < 5'h08) begin
            analog_onehot[analog_sel_reg[2:0]] = 1'b1;
        end
    end

    assign pa.latch = lat_a_reg;
    assign pa.dir = dir_a_reg;
    assign pa.pull_en = pull_a_reg;
    assign pa.analog = 8'h00;
    assign pa.pin_sync = sync_a;
    assign pb.latch = lat_b_reg;
    assign pb.dir = dir_b_reg;
    assign pb.pull_en = 8'h00;
    assign pb.analog = analog_onehot;
    assign pb.pin_sync = sync_b;
    assign pc.latch = lat_c_reg;
    assign pc.dir = dir_c_reg;
    assign pc.pull_en = pull_c_reg;
    assign pc.analog = 8'h00;
    assign pc.pin_sync = sync_c;

    gpio_pin_slice u_slice_a (.pin_sync_in(sync_a), .p(pa.slice));
    gpio_pin_slice u_slice_b (.pin_sync_in(sync_b), .p(pb.slice));
    gpio_pin_slice u_slice_c (.pin_sync_in(sync_c), .p(pc.slice));

    always_comb begin
        lat_a_next = lat_a_reg;
        lat_b_next = lat_b_reg;
        lat_c_next = lat_c_reg;
        dir_a_next = dir_a_reg;
        dir_b_next = dir_b_reg;
        dir_c_next = dir_c_reg;
        pull_a_next = pull_a_reg;
        pull_c_next = pull_c_reg;
        keypad_irq_control_next = keypad_irq_control_reg;
        analog_sel_next = analog_sel_reg;
        if (wr_in) begin
            // latch writes ignore direction
            if (hit(addr_in, `PORT_A_LATCH_OFS))
                lat_a_next = wdata_in;
            if (hit(addr_in, `PORT_B_LATCH_OFS))
                lat_b_next = wdata_in;
            if (hit(addr_in, `PORT_C_LATCH_OFS))
                lat_c_next = {1'b0, wdata_in[6:0]};
            if (hit(addr_in, `PORT_A_DIR_OFS))
                dir_a_next = wdata_in;
            if (hit(addr_in, `PORT_B_DIR_OFS))
                dir_b_next = wdata_in;
            if (hit(addr_in, `PORT_C_DIR_OFS))
                dir_c_next = {1'b0, wdata_in[6:0]};
            if (hit(addr_in, `PORT_A_PULL_OFS))
                pull_a_next = wdata_in;
            if (hit(addr_in, `PORT_C_PULL_OFS))
                pull_c_next = {1'b0, wdata_in[6:0]};
            if (hit(addr_in, `KEYPAD_CTRL_OFS))
                keypad_irq_control_next = wdata_in;
            if (hit(addr_in, `ANALOG_SEL_OFS))
                analog_sel_next = wdata_in[4:0];
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `PORT_A_LATCH_OFS: rdata_next = pa.read_val;
                `PORT_B_LATCH_OFS: rdata_next = pb.read_val;
                `PORT_C_LATCH_OFS: rdata_next = {1'b0, pc.read_val[6:0]};
                `PORT_A_DIR_OFS: rdata_next = dir_a_reg;
                `PORT_B_DIR_OFS: rdata_next = dir_b_reg;
                `PORT_C_DIR_OFS: rdata_next = dir_c_reg;
                `PORT_A_PULL_OFS: rdata_next = pull_a_reg;
                `PORT_C_PULL_OFS: rdata_next = pull_c_reg;
                `KEYPAD_CTRL_OFS: rdata_next = keypad_irq_control_reg;
                `ANALOG_SEL_OFS: rdata_next = {3'h0, analog_sel_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // latches keep their contents over reset, so no reset branch
    always_ff @(posedge ref_clk_in) begin
        lat_a_reg <= lat_a_next;
        lat_b_reg <= lat_b_next;
        lat_c_reg <= lat_c_next;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dir_a_reg <= `DIR_RESET;
            dir_b_reg <= `DIR_RESET;
            dir_c_reg <= `DIR_RESET;
            pull_a_reg <= `PULL_RESET;
            pull_c_reg <= `PULL_RESET;
            keypad_irq_control_reg <= `KEYPAD_RESET;
            analog_sel_reg <= `ANALOG_SEL_RESET;
            rdata_reg <= 8'h00;
        end else begin
            dir_a_reg <= dir_a_next;
            dir_b_reg <= dir_b_next;
            dir_c_reg <= dir_c_next;
            pull_a_reg <= pull_a_next;
            pull_c_reg <= pull_c_next;
            keypad_irq_control_reg <= keypad_irq_control_next;
            analog_sel_reg <= analog_sel_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign port_a_pin_out = pa.drive;
    assign port_a_pin_oe_out = pa.oe;
    assign port_a_pullup_out = pa.pull;
    assign port_b_pin_out = pb.drive;
    assign port_b_pin_oe_out = pb.oe;
    assign analog_channel_pins_out = analog_onehot;
    assign port_c_pin_out = pc.drive[6:0];
    assign port_c_pin_oe_out = pc.oe[6:0];
    assign port_c_pullup_out = pc.pull[6:0];
    // enabled first-port pins pass their synced level on
    assign keypad_inputs_out = sync_a & keypad_irq_control_reg;
endmodule
`default_nettype wire

// file: hdl/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

`define PORT_A_LATCH_OFS 8'h00
`define PORT_B_LATCH_OFS 8'h01
`define PORT_C_LATCH_OFS 8'h02
`define PORT_A_DIR_OFS 8'h04
`define PORT_B_DIR_OFS 8'h05
`define PORT_C_DIR_OFS 8'h06
`define PORT_A_PULL_OFS 8'h0d
`define PORT_C_PULL_OFS 8'h0c
`define KEYPAD_CTRL_OFS 8'h1a
`define ANALOG_SEL_OFS 8'h3c
`define DIR_RESET 8'h00
`define PULL_RESET 8'h00
`define KEYPAD_RESET 8'h00
`define ANALOG_SEL_RESET 5'h1f
`define ANALOG_SEL_W 5
`define PORT_C_W 7

`endif

// file: hdl/gpio_pkg.sv
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        SEL_PINS = 3'b001,
        SEL_LATCH = 3'b010,
        SEL_ANALOG = 3'b100
    } pin_src_t;
endpackage

// file: hdl/gpio_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gpio_pin_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pull_en;
    logic [7:0] analog;
    logic [7:0] pin_sync;
    logic [7:0] read_val;
    logic [7:0] drive;
    logic [7:0] oe;
    logic [7:0] pull;
    modport core (output latch, dir, pull_en, analog,
        input pin_sync, read_val, drive, oe, pull);
    modport slice (input latch, dir, pull_en, analog,
        output read_val, drive, oe, pull);
endinterface
`default_nettype wire

// file: hdl/gpio_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_sync (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;
    logic [7:0] meta_next;
    logic [7:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: hdl/gpio_pin_slice.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_slice (
    input wire logic [7:0] pin_sync_in,
    gpio_pin_if.slice p
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_comb begin
                // analog selection overrides direction, pullup and read data; drive still follows the latch
                if (p.analog[i]) begin
                    p.oe[i] = 1'b0;
                    p.pull[i] = 1'b0;
                    p.read_val[i] = 1'b0;
                end else begin
                    p.oe[i] = p.dir[i];
                    // pullup only while an input
                    p.pull[i] = p.pull_en[i] & ~p.dir[i];
                    p.read_val[i] = p.dir[i] ? p.latch[i] : pin_sync_in[i];
                end
                p.drive[i] = p.latch[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: testbench/gpio_sva.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_sva (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] port_a_pin_in,
    input wire logic [7:0] port_a_pin_out,
    input wire logic [7:0] port_a_pin_oe_out,
    input wire logic [7:0] port_a_pullup_out,
    input wire logic [7:0] port_b_pin_oe_out,
    input wire logic [7:0] analog_channel_pins_out,
    input wire logic [6:0] port_c_pin_out,
    input wire logic [6:0] port_c_pin_oe_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // three quiet cycles fill both synchroniser stages
    sequence a_quiet;
        (port_a_pin_oe_out == 8'h00 && $stable(port_a_pin_in))[*3];
    endsequence
    sequence a_read;
        rd_in && addr_in == 8'h00;
    endsequence
    dir_drive_a:
    assert property (wr_in && addr_in == 8'h04 |=>
        port_a_pin_oe_out == $past(wdata_in)) else $error("dir a");
    latch_load_a:
    assert property (wr_in && addr_in == 8'h00 |=>
        port_a_pin_out == $past(wdata_in)) else $error("latch a");
    c_latch_a:
    assert property (wr_in && addr_in == 8'h02 |=>
        {1'b0, port_c_pin_out} == ($past(wdata_in) & 8'h7f))
        else $error("latch c");
    pull_gate_a:
    assert property (wr_in && addr_in == 8'h0d |=> port_a_pullup_out ==
        ($past(wdata_in) & ~port_a_pin_oe_out)) else $error("pull a");
    analog_off_a:
    assert property ((port_b_pin_oe_out & analog_channel_pins_out) == 8'h00)
        else $error("analog oe");
    reset_dir_a:
    assert property ($rose(rst_b_in) |-> port_a_pin_oe_out == 8'h00 &&
        port_b_pin_oe_out == 8'h00 && port_c_pin_oe_out == 7'h00)
        else $error("reset dir");
    out_read_a:
    assert property (a_read |=> ((rdata_out ^ $past(port_a_pin_out)) &
        $past(port_a_pin_oe_out)) == 8'h00) else $error("out read");
    pin_read_a:
    assert property (a_quiet ##0 a_read |=>
        rdata_out == $past(port_a_pin_in)) else $error("pin read");
endmodule
bind three_port_gpio_block gpio_sva chk_u (.ref_clk_in, .rst_b_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .port_a_pin_in,
    .port_a_pin_out, .port_a_pin_oe_out, .port_a_pullup_out,
    .port_b_pin_oe_out, .analog_channel_pins_out, .port_c_pin_out,
    .port_c_pin_oe_out);
`default_nettype wire

// file: testbench/gpio_pins.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_pins #(parameter int W = 8) (
    input wire logic [W-1:0] drive_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] pull_in,
    input wire logic [W-1:0] ext_in,
    output logic [W-1:0] level_out
);
    // driven pins show the latch; pulled inputs float high
    always_comb level_out = (oe_in & drive_in) | (~oe_in & (pull_in | ext_in));
endmodule
`default_nettype wire

// file: testbench/three_port_gpio_block_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module three_port_gpio_block_tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] a_ext = 8'h3c;
    logic [7:0] b_ext = 8'h0c;
    logic [6:0] c_ext = 7'h00;
    logic [7:0] rdata_out, a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, ana, kp;
    logic [6:0] c_in, c_out, c_oe, c_pu;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    three_port_gpio_block dut_u (.ref_clk_in, .rst_b_in, .addr_in,
        .wdata_in, .wr_in, .rd_in, .rdata_out, .port_a_pin_in(a_in),
        .port_a_pin_out(a_out), .port_a_pin_oe_out(a_oe),
        .port_a_pullup_out(a_pu), .port_b_pin_in(b_in),
        .port_b_pin_out(b_out), .port_b_pin_oe_out(b_oe),
        .analog_channel_pins_out(ana), .port_c_pin_in(c_in),
        .port_c_pin_out(c_out), .port_c_pin_oe_out(c_oe),
        .port_c_pullup_out(c_pu), .keypad_inputs_out(kp));
    gpio_pins #(.W(8)) pa_u (.drive_in(a_out), .oe_in(a_oe), .pull_in(a_pu),
        .ext_in(a_ext), .level_out(a_in));
    gpio_pins #(.W(8)) pb_u (.drive_in(b_out), .oe_in(b_oe),
        .pull_in(8'h00), .ext_in(b_ext), .level_out(b_in));
    gpio_pins #(.W(7)) pc_u (.drive_in(c_out), .oe_in(c_oe), .pull_in(c_pu),
        .ext_in(c_ext), .level_out(c_in));
    task automatic close_out;
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(nm, rdata_out, e);
    endtask
    // budget is well above the roughly 70 cycles the sequence needs
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        for (int i = 4; i < 7; i++) rd("dir", 8'(i), 8'h00);
        wr(8'h00, 8'ha5);
        chk("latch a", a_out, 8'ha5);
        rd("pin a", 8'h00, 8'h3c);
        wr(8'h0d, 8'hf0);
        chk("pull a", a_pu, 8'hf0);
        repeat (3) @(posedge ref_clk_in);
        rd("pulled a", 8'h00, 8'hfc);
        wr(8'h04, 8'h0f);
        chk("oe a", a_oe, 8'h0f);
        repeat (3) @(posedge ref_clk_in);
        rd("mixed a", 8'h00, 8'hf5);
        wr(8'h04, 8'hff);
        chk("pull off", a_pu, 8'h00);
        rd("dir a", 8'h04, 8'hff);
        wr(8'h04, 8'h00);
        wr(8'h1a, 8'h0f);
        repeat (3) @(posedge ref_clk_in);
        chk("keypad", kp, 8'h0c);
        wr(8'h02, 8'h2a);
        wr(8'h06, 8'hd5);
        chk("oe c", {1'b0, c_oe}, 8'h55);
        rd("dir c", 8'h06, 8'h55);
        wr(8'h0c, 8'hff);
        chk("pull c", {1'b0, c_pu}, 8'h2a);
        repeat (3) @(posedge ref_clk_in);
        rd("pin c", 8'h02, 8'h2a);
        wr(8'h01, 8'h0f);
        chk("latch b", b_out, 8'h0f);
        wr(8'h05, 8'hff);
        wr(8'h3c, 8'h03);
        chk("analog sel", ana, 8'h08);
        chk("oe b", b_oe, 8'hf7);
        rd("pin b", 8'h01, 8'h07);
        wr(8'h3c, 8'h1f);
        chk("analog none", ana, 8'h00);
        rd("unmapped", 8'h7f, 8'h00);
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        chk("oe in reset", b_oe, 8'h00);
        chk("latch kept", a_out, 8'ha5);
        rst_b_in <= 1'b1;
        rd("dir b", 8'h05, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
